// >>> rtl/egm_pkg.sv
package egm_pkg;

   // ****************************************
   // Byte path and elastic buffer
   // ****************************************
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned TXFIFO_AW = 4;
   localparam int unsigned TXFIFO_DEPTH = 16;
   localparam logic [4:0] TXFIFO_HALF = 5'h08;
   localparam logic [4:0] TXFIFO_SLACK = 5'h02;
   localparam logic [4:0] TXFIFO_FULL = 5'h10;

   // ****************************************
   // Reference clock derived from core_clk
   // ****************************************
   localparam int unsigned CORE_CLK_MHZ = 200;
   localparam int unsigned REF_NORMAL_MHZ = 125;
   localparam int unsigned REF_FAST_MHZ = 312;
   // Half period of the byte clock in core cycles; 200 MHz cannot
   // divide exactly to the nominal rates, so an even divider of four core cycles (50 MHz) is used
   localparam logic [1:0] REF_HALF_CYC = 2'h2;

   // ****************************************
   // Speeds and buffer kinds
   // ****************************************
   typedef enum logic [1:0] {
      EGM_SPD_10 = 2'b00,
      EGM_SPD_100 = 2'b01,
      EGM_SPD_1000 = 2'b11
   } egm_speed_t;

   typedef enum logic [1:0] {
      EGM_BUF_TENBIT = 2'b00,
      EGM_BUF_XCVR = 2'b01,
      EGM_BUF_LOGIC = 2'b11
   } egm_buf_t;

   // Byte repeat counts per speed
   localparam logic [6:0] REP_1000 = 7'h01;
   localparam logic [6:0] REP_100 = 7'h0A;
   localparam logic [6:0] REP_10 = 7'h64;

   // Sustained frame limits in bytes
   localparam logic [15:0] LIM_CORR = 16'h4E20;
   localparam logic [15:0] LIM_XCVR_100 = 16'h2328;
   localparam logic [15:0] LIM_BUF_10 = 16'h0AF0;
   localparam logic [15:0] LIM_XCVR_10 = 16'h0384;

endpackage

// >>> rtl/egm_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none
module egm_skid_buf (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [9:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [9:0] outData
);

   // ****************************************
   // Two-entry storage
   // ****************************************
   logic [9:0] mem_q [2];
   logic wrPtr_q;
   logic rdPtr_q;
   logic [1:0] count_q;
   wire doWrite = inValid && inReady;
   wire doRead = outValid && outReady;

   assign inReady = (count_q != 2'h2);
   assign outValid = (count_q != 2'h0);
   assign outData = mem_q[rdPtr_q];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wrPtr_q <= 1'b0;
         rdPtr_q <= 1'b0;
         count_q <= 2'h0;
      end else begin
         if (doWrite) begin
            wrPtr_q <= ~wrPtr_q;
         end
         if (doRead) begin
            rdPtr_q <= ~rdPtr_q;
         end
         count_q <= count_q + {1'b0, doWrite} - {1'b0, doRead};
      end
   end

   // Storage needs no reset; it is never read while empty
   always_ff @(posedge core_clk) begin
      if (doWrite) begin
         mem_q[wrPtr_q] <= inData;
      end
   end

endmodule
`default_nettype wire

// >>> rtl/egm_gmii_adapter.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Transmit signals retimed through elastic buffer
// - Transmit data sampled, then recaptured at once
// - Receive outputs come straight from registers
// - Forwarded clock made by output register
// - Forwarded clock inverted, rising mid-window
// - All receive logic on core clock
// - Sustained limits 20000 or 9000 bytes
// - 10 Mb/s limits 2800 or 900 bytes
// - Jumbo frames follow the same limits
// - Correction touches only plain idle words
// - 100 Mb/s repeats every byte ten times
module egm_gmii_adapter (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Configuration
   input wire logic [1:0] speedSel,
   input wire logic [1:0] bufSel,
   // Transmit pins from the external MAC
   input wire logic gmiiTxClk,
   input wire logic [7:0] gmiiTxData,
   input wire logic gmiiTxEn,
   input wire logic gmiiTxEr,
   // Transmit bytes toward the core
   output logic coreTxValid,
   output logic [7:0] coreTxData,
   output logic coreTxEn,
   output logic coreTxEr,
   output logic txOverflow,
   output logic txUnderflow,
   // Receive bytes from the core
   input wire logic coreRxValid,
   output logic coreRxReady,
   input wire logic [7:0] coreRxData,
   input wire logic coreRxDv,
   input wire logic coreRxEr,
   // Receive pins toward the external MAC
   output logic gmiiRxClk,
   output logic [7:0] gmiiRxData,
   output logic gmiiRxDv,
   output logic gmiiRxEr,
   output logic rxFrameTooLong
);

   // ****************************************
   // Byte clock phase from the core clock
   // ****************************************
   logic [1:0] divCnt_q;
   logic phase_q;
   wire divWrap = (divCnt_q == egm_pkg::REF_HALF_CYC - 2'h1);
   wire byteTick = divWrap && phase_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         divCnt_q <= 2'h0;
         phase_q <= 1'b0;
      end else begin
         divCnt_q <= divWrap ? 2'h0 : divCnt_q + 2'h1;
         phase_q <= divWrap ? ~phase_q : phase_q;
      end
   end

   // ****************************************
   // Transmit pin capture
   // ****************************************
   logic [2:0] clkSync_q;
   logic [9:0] padStage_q;
   logic [9:0] regStage_q;
   logic [9:0] dataStage_q;
   logic clkLevel_q;
   wire clkStable = (clkSync_q[1] == clkSync_q[2]);
   wire txRise = clkStable && clkSync_q[2] && !clkLevel_q;

   // Pad flop, then immediate recapture, then a third stage as for the clock
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clkSync_q <= 3'h0;
         padStage_q <= 10'h000;
         regStage_q <= 10'h000;
         dataStage_q <= 10'h000;
         clkLevel_q <= 1'b0;
      end else begin
         clkSync_q <= {clkSync_q[1:0], gmiiTxClk};
         padStage_q <= {gmiiTxEn, gmiiTxEr, gmiiTxData};
         regStage_q <= padStage_q;
         dataStage_q <= regStage_q;
         clkLevel_q <= clkStable ? clkSync_q[2] : clkLevel_q;
      end
   end

   // ****************************************
   // Transmit elastic buffer
   // ****************************************
   logic [9:0] fifo_q [egm_pkg::TXFIFO_DEPTH];
   logic [3:0] wrPtr_q;
   logic [3:0] rdPtr_q;
   logic [4:0] occ_q;
   logic lastInIdle_q;
   logic lastOutIdle_q;
   logic started_q;

   // A plain idle has enable and error low; carrier extend keeps error high
   wire inIdle = !dataStage_q[9] && !dataStage_q[8];
   wire headIdle = !fifo_q[rdPtr_q][9] && !fifo_q[rdPtr_q][8];
   wire fifoFull = (occ_q == egm_pkg::TXFIFO_FULL);
   wire fifoEmpty = (occ_q == 5'h00);
   wire dropWord = inIdle && lastInIdle_q &&
      (occ_q > egm_pkg::TXFIFO_HALF + egm_pkg::TXFIFO_SLACK);
   wire holdRead = headIdle && lastOutIdle_q &&
      (occ_q < egm_pkg::TXFIFO_HALF - egm_pkg::TXFIFO_SLACK);
   wire doWrite = txRise && !dropWord && !fifoFull;
   wire doRead = byteTick && started_q && !fifoEmpty && !holdRead;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wrPtr_q <= 4'h0;
         rdPtr_q <= 4'h0;
         occ_q <= 5'h00;
         lastInIdle_q <= 1'b1;
         lastOutIdle_q <= 1'b1;
         started_q <= 1'b0;
      end else begin
         wrPtr_q <= doWrite ? wrPtr_q + 4'h1 : wrPtr_q;
         rdPtr_q <= doRead ? rdPtr_q + 4'h1 : rdPtr_q;
         occ_q <= occ_q + {4'h0, doWrite} - {4'h0, doRead};
         lastInIdle_q <= txRise ? inIdle : lastInIdle_q;
         lastOutIdle_q <= doRead ? headIdle : lastOutIdle_q;
         // Reading waits until the buffer first reaches half full
         started_q <= started_q || (occ_q >= egm_pkg::TXFIFO_HALF);
      end
   end

   always_ff @(posedge core_clk) begin
      if (doWrite) begin
         fifo_q[wrPtr_q] <= dataStage_q;
      end
   end

   // Core-side byte, one per byte clock; an inserted word repeats an idle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         coreTxValid <= 1'b0;
         coreTxData <= 8'h00;
         coreTxEn <= 1'b0;
         coreTxEr <= 1'b0;
         txOverflow <= 1'b0;
         txUnderflow <= 1'b0;
      end else begin
         coreTxValid <= byteTick;
         if (doRead) begin
            {coreTxEn, coreTxEr, coreTxData} <= fifo_q[rdPtr_q];
         end else if (byteTick) begin
            {coreTxEn, coreTxEr, coreTxData} <= 10'h000;
         end
         txOverflow <= txRise && fifoFull && !dropWord;
         txUnderflow <= byteTick && started_q && fifoEmpty;
      end
   end

   // ****************************************
   // Receive path, core clock only
   // ****************************************
   logic bufValid;
   logic [9:0] bufData;
   logic [6:0] repCnt_q;
   logic [15:0] frameLen_q;
   logic [6:0] repLimit;
   logic [15:0] lenLimit;
   wire lastRep = (repCnt_q >= repLimit - 7'h01);
   wire bufPop = byteTick && bufValid && lastRep;

   // Stall from the pins reaches the core through the skid buffer
   egm_skid_buf rxBuf (
      .core_clk(core_clk),
      .rst(rst),
      .inValid(coreRxValid),
      .inReady(coreRxReady),
      .inData({coreRxDv, coreRxEr, coreRxData}),
      .outValid(bufValid),
      .outReady(bufPop),
      .outData(bufData)
   );

   assign repLimit = (speedSel == egm_pkg::EGM_SPD_100) ? egm_pkg::REP_100 :
      (speedSel == egm_pkg::EGM_SPD_10) ? egm_pkg::REP_10 : egm_pkg::REP_1000;

   // Limits count client bytes, so repeats are not counted twice
   assign lenLimit = (speedSel == egm_pkg::EGM_SPD_10) ?
      ((bufSel == egm_pkg::EGM_BUF_XCVR) ? egm_pkg::LIM_XCVR_10 : egm_pkg::LIM_BUF_10) :
      ((speedSel == egm_pkg::EGM_SPD_100) && (bufSel == egm_pkg::EGM_BUF_XCVR)) ?
      egm_pkg::LIM_XCVR_100 : egm_pkg::LIM_CORR;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         repCnt_q <= 7'h00;
         frameLen_q <= 16'h0000;
         rxFrameTooLong <= 1'b0;
      end else if (byteTick && bufValid) begin
         repCnt_q <= lastRep ? 7'h00 : repCnt_q + 7'h01;
         if (lastRep && bufData[9]) begin
            frameLen_q <= (frameLen_q == 16'hFFFF) ? frameLen_q : frameLen_q + 16'h0001;
            rxFrameTooLong <= rxFrameTooLong || (frameLen_q >= lenLimit);
         end else if (lastRep) begin
            frameLen_q <= 16'h0000;
         end
      end
   end

   // Output cell registers; data launched as the inverse of phase_q rises
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         gmiiRxData <= 8'h00;
         gmiiRxDv <= 1'b0;
         gmiiRxEr <= 1'b0;
         // Follows phase_q from reset on, so the first low half is not cut short
         gmiiRxClk <= 1'b0;
      end else begin
         if (byteTick) begin
            // Starved buffer shows an idle byte rather than stale data
            {gmiiRxDv, gmiiRxEr, gmiiRxData} <= bufValid ? bufData : 10'h000;
         end
         // Copy of phase_q, the inverse of the launch phase: falls as data
         // is launched and rises two cycles later, mid data window
         gmiiRxClk <= divWrap ? ~phase_q : phase_q;
      end
   end

endmodule
`default_nettype wire

// >>> verif/egm_gmii_adapter_sva.sv
`timescale 1ns/1ps
`default_nettype none
module egm_gmii_adapter_sva (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Watched ports
   input wire logic [1:0] speedSel,
   input wire logic coreTxValid,
   input wire logic [7:0] coreTxData,
   input wire logic coreTxEn,
   input wire logic coreTxEr,
   input wire logic gmiiRxClk,
   input wire logic [7:0] gmiiRxData,
   input wire logic gmiiRxDv,
   input wire logic gmiiRxEr,
   input wire logic rxFrameTooLong
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic [9:0] rxWord;
   logic [9:0] lastRx_q;
   logic [5:0] holdCnt_q;
   logic seen_q;
   logic rxChg;
   assign rxWord = {gmiiRxDv, gmiiRxEr, gmiiRxData};
   assign rxChg = rxWord != lastRx_q;
   // Counts how long the current pin word has been held; saturates
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lastRx_q <= 10'h000;
         holdCnt_q <= 6'h00;
         seen_q <= 1'b0;
      end else begin
         lastRx_q <= rxWord;
         seen_q <= seen_q | rxChg;
         holdCnt_q <= rxChg ? 6'h00 : holdCnt_q + {5'h00, holdCnt_q != 6'h3F};
      end
   end
   a_rxclk_mid_rise: assert property ($fell(gmiiRxClk) |-> ##2 $rose(gmiiRxClk))
      else $error("forwarded clock did not rise mid-window");
   a_rxclk_fall_period: assert property ($fell(gmiiRxClk) |-> ##4 $fell(gmiiRxClk))
      else $error("forwarded clock period wrong");
   a_rx_launch_edge: assert property ($changed(rxWord) |-> $fell(gmiiRxClk))
      else $error("receive pins changed away from launch edge");
   a_tx_tick_period: assert property (coreTxValid |-> ##4 coreTxValid)
      else $error("transmit byte tick missing");
   a_tx_pulse_gap: assert property (coreTxValid |=> !coreTxValid [*3])
      else $error("transmit valid not a single pulse");
   a_tx_byte_stands: assert property ($changed({coreTxData, coreTxEn, coreTxEr}) |-> coreTxValid)
      else $error("transmit byte changed between ticks");
   a_rx_repeat_ten: assert property (speedSel == 2'b01 && seen_q && rxChg && gmiiRxDv
      && lastRx_q[9] |-> holdCnt_q >= 6'h27)
      else $error("byte not held ten ticks");
   a_toolong_sticky: assert property (rxFrameTooLong |=> rxFrameTooLong)
      else $error("frame length flag dropped");
   cover property (coreTxValid && coreTxEn);
   cover property ($rose(rxFrameTooLong));
   cover property (speedSel == 2'b01 && gmiiRxDv && rxChg);
endmodule
bind egm_gmii_adapter egm_gmii_adapter_sva u_sva (.core_clk(core_clk), .rst(rst),
   .speedSel(speedSel), .coreTxValid(coreTxValid), .coreTxData(coreTxData),
   .coreTxEn(coreTxEn), .coreTxEr(coreTxEr), .gmiiRxClk(gmiiRxClk), .gmiiRxData(gmiiRxData),
   .gmiiRxDv(gmiiRxDv), .gmiiRxEr(gmiiRxEr), .rxFrameTooLong(rxFrameTooLong));
`default_nettype wire

// >>> verif/egm_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module egm_mac_model (
   // Transmit pins toward the adapter
   output logic gmiiTxClk,
   output logic [7:0] gmiiTxData,
   output logic gmiiTxEn,
   output logic gmiiTxEr,
   // Receive pins from the adapter
   input wire logic gmiiRxClk,
   input wire logic [7:0] gmiiRxData,
   input wire logic gmiiRxDv
);
   logic [7:0] rxQ[$];
   initial begin
      gmiiTxClk = 1'b0;
      gmiiTxData = 8'hFF;
      gmiiTxEn = 1'b0;
      gmiiTxEr = 1'b0;
   end
   // Sampled mid-window on the forwarded clock's rise
   always @(posedge gmiiRxClk) if (gmiiRxDv) rxQ.push_back(gmiiRxData);
   // Clock runs only within a burst; stale data is inverted afterwards
   task automatic send(input int n);
      for (int i = 0; i < n + 16; i++) begin
         gmiiTxEn = (i >= 12) && (i < n + 12);
         gmiiTxData = gmiiTxEn ? 8'(i + 4) : 8'h00;
         #24 gmiiTxClk = 1'b1;
         #24 gmiiTxClk = 1'b0;
      end
      gmiiTxData = ~gmiiTxData;
   endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] speedSel = 2'b11;
   logic [1:0] bufSel = 2'b00;
   logic coreRxValid = 1'b0;
   logic coreRxDv = 1'b0;
   logic coreRxEr = 1'b0;
   logic [7:0] coreRxData = 8'h00;
   logic gmiiTxClk, gmiiTxEn, gmiiTxEr, coreTxValid, coreTxEn, coreTxEr, txOverflow;
   logic txUnderflow, coreRxReady, gmiiRxClk, gmiiRxDv, gmiiRxEr, rxFrameTooLong;
   logic [7:0] gmiiTxData, coreTxData, gmiiRxData;
   logic [7:0] txQ[$];
   int fail_count = 0;
   int n_checks = 0;
   int stalls = 0;
   int cyc = 0;
   int txOvf = 0;
   int txUnd = 0;
   always #2.5 core_clk = ~core_clk;
   egm_gmii_adapter dut (.core_clk(core_clk), .rst(rst), .speedSel(speedSel), .bufSel(bufSel),
      .gmiiTxClk(gmiiTxClk), .gmiiTxData(gmiiTxData), .gmiiTxEn(gmiiTxEn), .gmiiTxEr(gmiiTxEr),
      .coreTxValid(coreTxValid), .coreTxData(coreTxData), .coreTxEn(coreTxEn),
      .coreTxEr(coreTxEr), .txOverflow(txOverflow), .txUnderflow(txUnderflow),
      .coreRxValid(coreRxValid), .coreRxReady(coreRxReady), .coreRxData(coreRxData),
      .coreRxDv(coreRxDv), .coreRxEr(coreRxEr), .gmiiRxClk(gmiiRxClk), .gmiiRxData(gmiiRxData),
      .gmiiRxDv(gmiiRxDv), .gmiiRxEr(gmiiRxEr), .rxFrameTooLong(rxFrameTooLong));
   egm_mac_model mac (.gmiiTxClk(gmiiTxClk), .gmiiTxData(gmiiTxData), .gmiiTxEn(gmiiTxEn),
      .gmiiTxEr(gmiiTxEr), .gmiiRxClk(gmiiRxClk), .gmiiRxData(gmiiRxData), .gmiiRxDv(gmiiRxDv));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Sampled mid-cycle; a dry buffer shows idle, so every enabled byte counts
   always @(negedge core_clk) begin
      cyc++;
      if (coreTxValid && coreTxEn) txQ.push_back(coreTxData);
      if (txOverflow) txOvf++;
      if (txUnderflow) txUnd++;
      if (cyc == 98000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic push(input logic dv, input logic [7:0] d);
      coreRxValid = 1'b1;
      coreRxDv = dv;
      coreRxData = d;
      while (coreRxReady !== 1'b1) begin
         stalls++;
         @(negedge core_clk);
      end
      @(negedge core_clk);
   endtask
   task automatic test_tx();
      txQ.delete();
      txOvf = 0;
      txUnd = 0;
      mac.send(16);
      repeat (40) @(negedge core_clk);
      check(16'(txQ.size()), 16'h0010);
      // The link is slower than the byte clock: never full, runs dry in a frame
      check(16'(txOvf), 16'h0000);
      check(16'(txUnd > 0), 16'h0001);
      for (int i = 0; i < 16; i++) check(16'(txQ[i]), 16'(16 + i));
      $display("tx burst test done");
   endtask
   task automatic test_rx(input logic [1:0] spd, input logic [1:0] bsel, input int rep);
      speedSel = spd;
      bufSel = bsel;
      stalls = 0;
      repeat (20) @(negedge core_clk);
      mac.rxQ.delete();
      repeat (2) push(1'b0, 8'h00);
      for (int i = 0; i < 6; i++) push(1'b1, 8'(160 + i));
      push(1'b0, 8'h00);
      coreRxValid = 1'b0;
      repeat (24 * rep + 40) @(negedge core_clk);
      check(16'(mac.rxQ.size()), 16'(6 * rep));
      for (int i = 0; i < 6 * rep; i++) check(16'(mac.rxQ[i]), 16'(160 + i / rep));
      check(16'(stalls > 0), 16'h0001);
      check(16'(gmiiRxEr), 16'h0000);
      $display("rx stream test done, repeat %0d", rep);
   endtask
   task automatic test_long();
      speedSel = 2'b11;
      bufSel = 2'b11;
      repeat (20) @(negedge core_clk);
      for (int i = 0; i < 20000; i++) push(1'b1, 8'(i));
      // Let the limit-sized frame drain fully before judging it
      coreRxValid = 1'b0;
      repeat (16) @(negedge core_clk);
      check(16'(rxFrameTooLong), 16'h0000);
      push(1'b1, 8'h55);
      push(1'b0, 8'h00);
      coreRxValid = 1'b0;
      repeat (16) @(negedge core_clk);
      check(16'(rxFrameTooLong), 16'h0001);
      $display("long frame test done");
   endtask
   initial begin
      repeat (6) @(negedge core_clk);
      rst = 1'b0;
      repeat (2) @(negedge core_clk);
      test_tx();
      test_rx(2'b00, 2'b01, 100);
      test_rx(2'b01, 2'b00, 10);
      test_rx(2'b11, 2'b11, 1);
      test_long();
      print_verdict();
   end
endmodule
`default_nettype wire
